//--- inc/bsie_cfg.svh
`ifndef BSIE_CFG_SVH
`define BSIE_CFG_SVH

// ==========================================================
// Register byte addresses
`define BSIE_ADDR_W 16
`define BSIE_OFS_ISTAT 16'h3060
`define BSIE_OFS_CSTAT 16'h306c
`define BSIE_OFS_MASK 16'h3070

// ==========================================================
// Current status word fields
`define BSIE_B_MASTER 3
`define BSIE_B_PEND 5
`define BSIE_B_INTA 6
`define BSIE_CSTAT_RSVD 32'hffffff97

// ==========================================================
// Interrupt status layout
`define BSIE_B_FALL 6
`define BSIE_B_RISE 7
`define BSIE_ERR_LIVE_LO 8
`define BSIE_ERR_LIVE_W 6
`define BSIE_ERR_LO_W 3
`define BSIE_MBOX_LO 16
`define BSIE_MBOX_N 8
`define BSIE_IMPL_BASE 32'h00ff3f07
`define BSIE_IMPL_HOST 32'h000000c0
`define BSIE_ERR_ROUTE_W 9

// ==========================================================
// Reset values and counts
`define BSIE_MASK_RST 32'h00000000
`define BSIE_PEND_W 5
`define BSIE_PEND_MAX 5'h1f
`define BSIE_LAG_MAX_CYC 5

`endif

//--- inc/bsie_pkg.sv
`include "bsie_cfg.svh"

package bsie_pkg;

    // ======================================================
    // State of the register front end
    typedef struct packed {
        logic [31:0] prdata;
        logic pslverr;
        logic [31:0] mask;
        logic irq;
        logic intan_prev;
        logic [`BSIE_ERR_ROUTE_W-1:0] err_route;
    } bsie_main_s;

    // ======================================================
    // State of the pending write tracker
    typedef struct packed {
        logic [`BSIE_PEND_W-1:0] cnt;
        logic flag;
    } bsie_pend_s;

    // ======================================================
    // State of the sticky status bits
    typedef struct packed {
        logic [31:0] bits;
    } bsie_stat_s;

endpackage : bsie_pkg

//--- core/bsie_pend.sv
`timescale 1ns/1ns
`default_nettype none
`include "bsie_cfg.svh"

module bsie_pend (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enter,
    input wire logic retire,
    output var logic pending
);
    import bsie_pkg::*;

    bsie_pend_s cur;
    bsie_pend_s nxt;

    always_comb begin
        nxt = cur;
        if (enter && !retire && cur.cnt != `BSIE_PEND_MAX) begin
            nxt.cnt = cur.cnt + `BSIE_PEND_W'(1);
        end else if (retire && !enter && cur.cnt != '0) begin
            nxt.cnt = cur.cnt - `BSIE_PEND_W'(1);
        end
        // Flag follows the count one cycle after entry
        nxt.flag = (nxt.cnt != '0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign pending = cur.flag;

    // ======================================================
    // Checks
    localparam int LAG = `BSIE_LAG_MAX_CYC;

    pend_lag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (enter && !retire) |-> ##[1:LAG] pending)
        else $error("pending flag not set in time");

    pend_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (retire && !enter && cur.cnt == `BSIE_PEND_W'(1)) |=> !pending)
        else $error("pending flag left set after last retire");

endmodule : bsie_pend
`default_nettype wire

//--- core/bsie_stat.sv
`timescale 1ns/1ns
`default_nettype none
`include "bsie_cfg.svh"

module bsie_stat (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] set_evt,
    input wire logic [31:0] clr_w1c,
    input wire logic [31:0] impl,
    output var logic [31:0] stat
);
    import bsie_pkg::*;

    bsie_stat_s cur;
    bsie_stat_s nxt;
    logic [31:0] bit_next;

    // Set wins over a same-cycle write-one-to-clear
    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_bit
            assign bit_next[i] = impl[i] &
                (set_evt[i] | (cur.bits[i] & ~clr_w1c[i]));
        end
    endgenerate

    always_comb begin
        nxt = cur;
        nxt.bits = bit_next;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign stat = cur.bits;

    // ======================================================
    // Checks
    stat_w1c_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_w1c[`BSIE_B_FALL] && !set_evt[`BSIE_B_FALL])
        |=> !stat[`BSIE_B_FALL])
        else $error("write one did not clear status bit");

    stat_set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        (set_evt[`BSIE_MBOX_LO] && impl[`BSIE_MBOX_LO])
        |=> stat[`BSIE_MBOX_LO])
        else $error("event lost against clear");

endmodule : bsie_stat
`default_nettype wire

//--- core/bsie_top.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "bsie_cfg.svh"

module bsie_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`BSIE_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    input wire logic host_mode,
    input wire logic target_only,
    input wire logic bus_master_en,
    input wire logic intan_n,
    input wire logic outbound_write_enter,
    input wire logic outbound_write_retire,
    input wire logic [`BSIE_ERR_LO_W-1:0] err_evt_lo,
    input wire logic [`BSIE_ERR_LIVE_W-1:0] err_live,
    input wire logic [`BSIE_MBOX_N-1:0] inbound_box_wr,
    output var logic [`BSIE_ERR_ROUTE_W-1:0] pci_err_route,
    output var logic local_irq_out
);
    import bsie_pkg::*;

    // ======================================================
    // Declarations
    bsie_main_s cur;
    bsie_main_s nxt;
    logic outbound_write_pending;
    logic [31:0] sticky;
    logic [31:0] status;
    logic [31:0] impl_vec;
    logic [31:0] set_evt;
    logic [31:0] clr_w1c;
    logic [31:0] cstat_word;
    logic live_master;
    logic live_inta;
    logic intan_fall;
    logic intan_rise;
    logic setup_ph;
    logic access_wr;

    // ======================================================
    // Mode dependent layout
    assign impl_vec = `BSIE_IMPL_BASE |
        (host_mode ? `BSIE_IMPL_HOST : 32'h00000000);
    assign live_master = bus_master_en & ~target_only;
    assign live_inta = intan_n & host_mode;

    // ======================================================
    // Event sources
    assign intan_fall = host_mode & cur.intan_prev & ~intan_n;
    assign intan_rise = host_mode & ~cur.intan_prev & intan_n;

    always_comb begin
        set_evt = 32'h00000000;
        set_evt[`BSIE_ERR_LO_W-1:0] = err_evt_lo;
        set_evt[`BSIE_B_FALL] = intan_fall;
        set_evt[`BSIE_B_RISE] = intan_rise;
        set_evt[`BSIE_MBOX_LO +: `BSIE_MBOX_N] = inbound_box_wr;
    end

    // ======================================================
    // APB phases
    assign setup_ph = psel & ~penable;
    assign access_wr = psel & penable & pwrite;
    assign pready = psel & penable;

    always_comb begin
        clr_w1c = 32'h00000000;
        if (access_wr && paddr == `BSIE_OFS_ISTAT) begin
            clr_w1c = pwdata;
        end
        // An INTA edge in the same cycle keeps both edge bits from clearing
        if (intan_fall || intan_rise) begin
            clr_w1c[`BSIE_B_FALL] = 1'b0;
            clr_w1c[`BSIE_B_RISE] = 1'b0;
        end
    end

    bsie_stat u_stat (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(set_evt),
        .clr_w1c(clr_w1c),
        .impl(impl_vec),
        .stat(sticky)
    );

    bsie_pend u_pend (
        .pclk(pclk),
        .presetn(presetn),
        .enter(outbound_write_enter),
        .retire(outbound_write_retire),
        .pending(outbound_write_pending)
    );

    // Error bits 13:8 are live copies, the rest are sticky
    always_comb begin
        status = sticky;
        status[`BSIE_ERR_LIVE_LO +: `BSIE_ERR_LIVE_W] = err_live;
    end

    // ======================================================
    // Current status word
    always_comb begin
        cstat_word = 32'h00000000;
        cstat_word[`BSIE_B_MASTER] = live_master;
        cstat_word[`BSIE_B_PEND] = outbound_write_pending;
        cstat_word[`BSIE_B_INTA] = live_inta;
    end

    // ======================================================
    // Next state
    always_comb begin
        nxt = cur;
        nxt.intan_prev = intan_n;
        // Drop enables whose status bit vanished with a mode change
        nxt.mask = cur.mask & impl_vec;
        if (setup_ph) begin
            nxt.pslverr = 1'b0;
            nxt.prdata = 32'h00000000;
            case (paddr)
                `BSIE_OFS_ISTAT: begin
                    nxt.prdata = pwrite ? 32'h00000000 : status;
                end
                `BSIE_OFS_CSTAT: begin
                    nxt.prdata = pwrite ? 32'h00000000 : cstat_word;
                end
                `BSIE_OFS_MASK: begin
                    nxt.prdata = pwrite ? 32'h00000000 : cur.mask;
                end
                default: begin
                    nxt.pslverr = 1'b1;
                end
            endcase
        end
        if (access_wr && paddr == `BSIE_OFS_MASK) begin
            nxt.mask = pwdata & impl_vec;
        end
        nxt.irq = |(status & cur.mask);
        nxt.err_route = {status[`BSIE_ERR_LIVE_LO +: `BSIE_ERR_LIVE_W],
            status[`BSIE_ERR_LO_W-1:0]};
    end

    // ======================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur.prdata <= 32'h00000000;
            cur.pslverr <= 1'b0;
            cur.mask <= `BSIE_MASK_RST;
            cur.irq <= 1'b0;
            cur.intan_prev <= 1'b1;
            cur.err_route <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign prdata = cur.prdata;
    assign pslverr = cur.pslverr & psel & penable;
    assign local_irq_out = cur.irq;
    assign pci_err_route = cur.err_route;

    // ======================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence rd_setup(logic [`BSIE_ADDR_W-1:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    sequence rd_access;
        psel && penable && pready;
    endsequence

    sequence istat_clr(int b);
        access_wr && paddr == `BSIE_OFS_ISTAT && pwdata[b];
    endsequence

    localparam int LAG_TOP = `BSIE_LAG_MAX_CYC;

    property cstat_bit_p(int b, logic v);
        rd_setup(`BSIE_OFS_CSTAT) ##1 rd_access |-> prdata[b] == v;
    endproperty

    master_mirror_a: assert property (
        rd_setup(`BSIE_OFS_CSTAT) |=> prdata[`BSIE_B_MASTER] ==
            $past(live_master))
        else $error("master bit does not mirror enable");

    target_zero_a: assert property (
        rd_setup(`BSIE_OFS_CSTAT) ##0 target_only
        |=> !prdata[`BSIE_B_MASTER])
        else $error("master bit set in target-only mode");

    pend_read_a: assert property (
        rd_setup(`BSIE_OFS_CSTAT) |=> prdata[`BSIE_B_PEND] ==
            $past(outbound_write_pending))
        else $error("pending bit read wrong");

    inta_level_a: assert property (
        rd_setup(`BSIE_OFS_CSTAT) ##0 host_mode
        |=> prdata[`BSIE_B_INTA] == $past(intan_n))
        else $error("INTA bit does not follow line");

    inta_host_only_a: assert property (
        rd_setup(`BSIE_OFS_CSTAT) ##0 !host_mode
        |=> !prdata[`BSIE_B_INTA])
        else $error("INTA bit present outside host mode");

    reserved_zero_a: assert property (
        rd_setup(`BSIE_OFS_CSTAT) ##1 rd_access
        |-> (prdata & `BSIE_CSTAT_RSVD) == 32'h00000000)
        else $error("reserved status bits not zero");

    mask_impl_a: assert property (
        (cur.mask & ~`BSIE_IMPL_BASE & ~`BSIE_IMPL_HOST) == 32'h00000000)
        else $error("unimplemented mask bit holds one");

    mask_write_a: assert property (
        (access_wr && paddr == `BSIE_OFS_MASK)
        |=> cur.mask == ($past(pwdata) & $past(impl_vec)))
        else $error("mask write not stored");

    irq_set_a: assert property (
        (|(status & cur.mask)) |=> local_irq_out)
        else $error("interrupt not raised for enabled status");

    irq_clear_a: assert property (
        (!(|(status & cur.mask)) ##1 !(|(status & cur.mask)))
        |-> !local_irq_out)
        else $error("interrupt held without enabled status");

    fall_set_a: assert property (
        (host_mode && cur.intan_prev && !intan_n) |=> sticky[`BSIE_B_FALL])
        else $error("INTA fall not captured");

    mbox_set_a: assert property (
        inbound_box_wr[0] |=> status[`BSIE_MBOX_LO])
        else $error("mailbox event not captured");

    err_route_a: assert property (
        ##1 pci_err_route[`BSIE_ERR_ROUTE_W-1:`BSIE_ERR_LO_W] ==
            $past(err_live))
        else $error("error route does not follow live errors");

    rd_hold_a: assert property (
        rd_setup(`BSIE_OFS_CSTAT) |=> pready ##1 $stable(prdata))
        else $error("read data not held after access phase");

    rsvd_bit4_a: assert property (cstat_bit_p(4, 1'b0))
        else $error("reserved status bit 4 not zero");

    rise_set_a: assert property (
        (host_mode && !cur.intan_prev && intan_n)
        |=> sticky[`BSIE_B_RISE])
        else $error("INTA rise not captured");

    edge_keeps_a: assert property (
        istat_clr(`BSIE_B_FALL) ##0 (intan_rise && sticky[`BSIE_B_FALL])
        |=> sticky[`BSIE_B_FALL])
        else $error("status bit 6 cleared during INTA edge");

    mbox_clear_a: assert property (
        istat_clr(`BSIE_MBOX_LO) ##0 !inbound_box_wr[0]
        |=> !sticky[`BSIE_MBOX_LO])
        else $error("mailbox status not cleared by write one");

    mbox_all_a: assert property (
        (|inbound_box_wr) |=> (sticky[`BSIE_MBOX_LO +: `BSIE_MBOX_N] &
            $past(inbound_box_wr)) == $past(inbound_box_wr))
        else $error("mailbox event lost");

    err_sticky_a: assert property (
        (|err_evt_lo) |=> (sticky[`BSIE_ERR_LO_W-1:0] & $past(err_evt_lo))
            == $past(err_evt_lo))
        else $error("error event lost");

    host_bits_a: assert property (
        !host_mode |=> sticky[`BSIE_B_RISE:`BSIE_B_FALL] == 2'b00)
        else $error("INTA edge bits held outside host mode");

    mask_host_a: assert property (
        !host_mode |=> cur.mask[`BSIE_B_RISE:`BSIE_B_FALL] == 2'b00)
        else $error("INTA edge enables held outside host mode");

    mask_read_a: assert property (
        rd_setup(`BSIE_OFS_MASK) |=> prdata == $past(cur.mask))
        else $error("mask read back wrong");

    status_read_a: assert property (
        rd_setup(`BSIE_OFS_ISTAT) |=> prdata == $past(status))
        else $error("status read back wrong");

    irq_off_a: assert property (
        (cur.mask == 32'h00000000) |=> !local_irq_out)
        else $error("interrupt raised with all enables off");

    irq_drop_a: assert property (
        !(|(status & cur.mask)) |=> !local_irq_out)
        else $error("interrupt held after enabled status cleared");

    pend_seen_a: assert property (
        (outbound_write_enter && !outbound_write_retire)
        |-> ##[1:LAG_TOP] cstat_word[`BSIE_B_PEND])
        else $error("pending bit late in current status");

endmodule : bsie_top
`default_nettype wire

//--- test/bsie_far_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Far side of the bridge: one-cycle commands become event pulses
module bsie_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [12:0] cmd,
    output var logic [12:0] evt
);
    // Bits: 12:5 mailbox writes, 4 retire, 3 enter, 2:0 errors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt <= '0;
        end else begin
            evt <= cmd;
        end
    end
endmodule : bsie_far_model

`default_nettype wire

//--- test/test_bridge_status_irq_enable.sv
`timescale 1ns/1ns
`default_nettype none
`include "bsie_cfg.svh"

module test_bridge_status_irq_enable;
    localparam logic [15:0] ist = `BSIE_OFS_ISTAT;
    localparam logic [15:0] cst = `BSIE_OFS_CSTAT;
    localparam logic [15:0] msk = `BSIE_OFS_MASK;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, q, m;
    logic pready, pslverr, local_irq_out, e;
    logic host_mode = 0;
    logic target_only = 0;
    logic bus_master_en = 0;
    logic intan_n = 1;
    logic [12:0] cmd = '0;
    logic [12:0] evt;
    logic [5:0] err_live = '0;
    logic [8:0] pci_err_route;
    int fail_count = 0;
    int check_count = 0;

    bsie_far_model i_far (.pclk(pclk), .presetn(presetn), .cmd(cmd),
        .evt(evt));
    bsie_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_mode(host_mode),
        .target_only(target_only), .bus_master_en(bus_master_en),
        .intan_n(intan_n), .outbound_write_enter(evt[3]),
        .outbound_write_retire(evt[4]), .err_evt_lo(evt[2:0]),
        .err_live(err_live), .inbound_box_wr(evt[12:5]),
        .pci_err_route(pci_err_route), .local_irq_out(local_irq_out));

    initial begin
        forever #5 pclk = ~pclk;
    end

    // ======================================================
    // Shared tasks
    task chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask : chk

    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task pulse(input logic [12:0] c);
        @(posedge pclk);
        cmd <= c;
        @(posedge pclk);
        cmd <= '0;
    endtask : pulse

    function logic [31:0] cstat_exp(input logic pend);
        cstat_exp = '0;
        cstat_exp[`BSIE_B_MASTER] = bus_master_en & ~target_only;
        cstat_exp[`BSIE_B_PEND] = pend;
        cstat_exp[`BSIE_B_INTA] = host_mode & intan_n;
    endfunction : cstat_exp

    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #300000;
        fail_count++;
        report_and_stop;
    end

    // ======================================================
    // Tests
    initial begin
        void'($urandom(8));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, msk, 0);
        chk(q, `BSIE_MASK_RST);
        for (int i = 0; i < 16; i++) begin
            {host_mode, target_only, bus_master_en, intan_n} <= i[3:0];
            apb(1, cst, $urandom);
            apb(0, cst, 0);
            chk(q, cstat_exp(0));
        end
        $display("test modes done");
        host_mode <= 1;
        intan_n <= 1;
        pulse(13'h8);
        apb(0, cst, 0);
        chk(q, cstat_exp(1));
        pulse(13'h8);
        pulse(13'h10);
        apb(0, cst, 0);
        chk(q, cstat_exp(1));
        pulse(13'h10);
        apb(0, cst, 0);
        chk(q, cstat_exp(0));
        apb(0, ist, 0);
        chk(q[2:0], 0);
        $display("test pending done");
        for (int i = 0; i < 8; i++) begin
            m = (i < 2) ? 32'hffffffff : $urandom;
            host_mode <= (i < 2) ? i[0] : m[0];
            apb(1, msk, m);
            apb(0, msk, 0);
            chk(q, m & (`BSIE_IMPL_BASE | (host_mode ?
                `BSIE_IMPL_HOST : 32'h0)));
        end
        $display("test mask done");
        host_mode <= 1;
        apb(1, ist, 32'hffffffff);
        for (int b = 0; b < 8; b++) begin
            apb(1, msk, 32'h1 << (16 + b));
            pulse(13'h20 << b);
            repeat (3) @(posedge pclk);
            chk(local_irq_out, 1);
            apb(0, ist, 0);
            chk(q, 32'h1 << (16 + b));
            apb(1, ist, q);
            repeat (2) @(posedge pclk);
            chk(local_irq_out, 0);
        end
        pulse(13'h40 << 1);
        repeat (3) @(posedge pclk);
        chk(local_irq_out, 0);
        apb(1, ist, 32'hffffffff);
        apb(1, msk, 32'h40);
        intan_n <= 0;
        repeat (3) @(posedge pclk);
        chk(local_irq_out, 1);
        apb(0, ist, 0);
        chk(q, 32'h40);
        apb(1, ist, 32'hc0);
        apb(0, ist, 0);
        chk(q, 32'h0);
        intan_n <= 1;
        repeat (2) @(posedge pclk);
        intan_n <= 0;
        repeat (2) @(posedge pclk);
        // Clear bit 6 while the line rises in the access cycle
        fork
            apb(1, ist, 32'h40);
            begin
                repeat (2) @(posedge pclk);
                intan_n <= 1;
            end
        join
        apb(0, ist, 0);
        chk(q, 32'hc0);
        apb(1, ist, 32'hc0);
        $display("test events done");
        // Error bits stay off the local mask
        apb(1, msk, 0);
        for (int i = 0; i < 5; i++) begin
            m = $urandom;
            err_live <= m[5:0];
            pulse({10'h0, m[8:6]});
            repeat (3) @(posedge pclk);
            chk(pci_err_route, {m[5:0], m[8:6]});
            chk(local_irq_out, 0);
            apb(1, ist, 32'h7);
        end
        apb(0, 16'h3074, 0);
        chk(e, 1);
        chk(q, 0);
        apb(0, msk, 0);
        chk(e, 0);
        $display("test errors done");
        report_and_stop;
    end
endmodule : test_bridge_status_irq_enable

`default_nettype wire
